// ---- pfs_board.sv ----
`timescale 1ns/10ps
// released pads follow the board's own level
module pfs_board (
   input  wire logic [15:0] pad_out,
   input  wire logic [15:0] pad_oe,
   input  wire logic [15:0] drive,
   output wire logic [15:0] pad_in
);
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & drive);
endmodule

// ---- pfs_map.vh ----
`ifndef PFS_MAP_VH
`define PFS_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PFS_OFF_FUNC    8'h00
`define PFS_OFF_DIR     8'h04
`define PFS_OFF_DOUT    8'h08
`define PFS_OFF_DIN     8'h0C
`define PFS_OFF_ANA     8'h10
`define PFS_OFF_RELOC   8'h14
`define PFS_OFF_IRQ     8'h18
`define PFS_OFF_CAP     8'h1C
`define PFS_OFF_STAT    8'h20
// ----------------------------------------
// relocation select fields
// ----------------------------------------
`define PFS_RS_BTA      0
`define PFS_RS_BTB      2
`define PFS_RS_ADS      4
`define PFS_RS_ADE      6
`define PFS_RS_FRS      7
`define PFS_RS_FRE      8
`define PFS_RS_DIS      9
`define PFS_RS_DIE      10
`define PFS_RS_WVS      11
`define PFS_RS_WVE      12
`define PFS_RS_PPG      13
`define PFS_RS_TRC      14
`define PFS_RS_SWJ      15
`define PFS_RS_EBE      16
`define PFS_RS_SPL      17
`define PFS_IRQ_SEL     16
`define PFS_CAP_EN      4
// ----------------------------------------
// pin positions of relocated functions
// ----------------------------------------
`define PFS_BTA_BASE    0
`define PFS_BTB_BASE    3
`define PFS_ADT_BASE    6
`define PFS_WAV_POS0    10
`define PFS_WAV_POS1    4
`define PFS_TRC_BASE    0
`define PFS_IRQ_ALT     8
`define PFS_CAP_POS0    10
`define PFS_CAP_POS1    2
`define PFS_FRK_POS0    14
`define PFS_DIS_POS0    12
// ----------------------------------------
// reset values
// ----------------------------------------
`define PFS_RST_16      16'h0000
`define PFS_RST_SEL     18'h00000
`define PFS_RST_CAP     8'h00
`endif

// ---- pfs_pin_ctrl.v ----
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "pfs_map.vh"
// Function
// - adc trigger on relocatable pins
// - analog pin k feeds channel k
// - timer a/b each on three positions
// - swd shares tck, tms, tdo pins
// - trace clock, four data, jtag reset
// - address bus 0..24 on own pins
// - sixteen relocatable irq lines plus nmi
// - disable input gates six waveform outputs
// - freerun timer external clock pin
// - four capture inputs, relocatable
// - ppg mode: pair carries lower ppg
// - supply unstable: pins high impedance
// - reset: hi-z, input on, config locked
// - standby with spl: port and address pins hi-z except trace pins, input zero
// - irq and nmi pins keep state
// - run or spl clear: keep state
// - software selects relocated position
module pfs_pin_ctrl (
   input  wire        clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        supply_unstable,
   input  wire        external_reset_n,
   input  wire        internal_reset,
   input  wire        standby_mode,
   input  wire [15:0] pad_in,
   output reg  [15:0] pad_out,
   output reg  [15:0] pad_oe,
   input  wire        bt_a_out,
   input  wire        bt_a_oe,
   input  wire        bt_b_out,
   input  wire        bt_b_oe,
   output reg         base_timer_io_a,
   output reg         base_timer_io_b,
   output reg         adc_ext_trigger,
   output reg  [15:0] analog_channel_input,
   input  wire [5:0]  waveform_output,
   input  wire [2:0]  pulse_gen_output,
   output reg         waveform_disable_n,
   output reg         freerun_ext_clock,
   output reg  [3:0]  capture_input,
   output reg  [15:0] ext_irq,
   input  wire        nmi_pad_in,
   output reg         nonmaskable_irq_n,
   input  wire        trace_clock_out,
   input  wire [3:0]  trace_data_out,
   input  wire [24:0] ext_bus_address,
   output reg  [24:0] addr_pad_out,
   output reg         addr_pad_oe,
   input  wire        tck_pad_in,
   input  wire        tms_pad_in,
   output reg         tms_pad_out,
   output reg         tms_pad_oe,
   output reg         tdo_pad_out,
   output reg         tdo_pad_oe,
   input  wire        jtag_reset_pad_n,
   output reg         jtag_reset_n,
   output reg         dbg_clock,
   output reg         dbg_tms,
   input  wire        dbg_swdio_out,
   input  wire        dbg_swdio_oe,
   input  wire        jtag_tdo,
   input  wire        jtag_tdo_oe,
   input  wire        swo_in
);

// ----------------------------------------
// configuration registers
// ----------------------------------------
reg  [15:0] func;
reg  [15:0] dir;
reg  [15:0] dout;
reg  [15:0] aen;
reg  [15:0] irq_en;
reg  [15:0] irq_sel;
reg  [17:0] rsel;
reg  [7:0]  cap;
reg  [31:0] rd_word;
reg         hit;
wire [15:0] pin_in;

wire        cfg_lock = ~external_reset_n | internal_reset;
wire        hold     = standby_mode & rsel[`PFS_RS_SPL];
wire        acc      = psel & penable & ~pready;
wire        apb_wr   = psel & penable & pready & pwrite;
wire [1:0]  a_sel    = rsel[`PFS_RS_BTA+1:`PFS_RS_BTA];
wire [1:0]  b_sel    = rsel[`PFS_RS_BTB+1:`PFS_RS_BTB];
wire [1:0]  ad_sel   = rsel[`PFS_RS_ADS+1:`PFS_RS_ADS];
wire [3:0]  cap_sel  = cap[3:0];
wire [3:0]  cap_en   = cap[`PFS_CAP_EN+3:`PFS_CAP_EN];

// input of the selected pin, zero unless it is in peripheral function
function sel_in;
   input [15:0] v;
   input [15:0] f;
   input integer p;
   begin
      sel_in = v[p] & f[p];
   end
endfunction

// ----------------------------------------
// apb slave
// ----------------------------------------
always @*
begin
   hit = 1'b1;
   case (paddr)
      `PFS_OFF_FUNC  : rd_word = {16'h0000, func};
      `PFS_OFF_DIR   : rd_word = {16'h0000, dir};
      `PFS_OFF_DOUT  : rd_word = {16'h0000, dout};
      `PFS_OFF_DIN   : rd_word = {16'h0000, pin_in};
      `PFS_OFF_ANA   : rd_word = {16'h0000, aen};
      `PFS_OFF_RELOC : rd_word = {14'h0000, rsel};
      `PFS_OFF_IRQ   : rd_word = {irq_sel, irq_en};
      `PFS_OFF_CAP   : rd_word = {24'h000000, cap};
      `PFS_OFF_STAT  : rd_word = {28'h0000000, hold, standby_mode, cfg_lock, supply_unstable};
      default:
      begin
         rd_word = 32'h00000000;
         hit     = 1'b0;
      end
   endcase
end

// one wait state: answer on the second access cycle
always @(posedge clk)
begin
   if (rst)
   begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
   end
   else
   begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      if (acc)
         prdata <= rd_word;
   end
end

always @(posedge clk)
begin
   if (rst | cfg_lock)
   begin
      func    <= `PFS_RST_16;
      dir     <= `PFS_RST_16;
      dout    <= `PFS_RST_16;
      aen     <= `PFS_RST_16;
      irq_en  <= `PFS_RST_16;
      irq_sel <= `PFS_RST_16;
      rsel    <= `PFS_RST_SEL;
      cap     <= `PFS_RST_CAP;
   end
   else if (apb_wr)
   begin
      case (paddr)
         `PFS_OFF_FUNC  : func <= pwdata[15:0];
         `PFS_OFF_DIR   : dir <= pwdata[15:0];
         `PFS_OFF_DOUT  : dout <= pwdata[15:0];
         `PFS_OFF_ANA   : aen <= pwdata[15:0];
         `PFS_OFF_RELOC : rsel <= pwdata[17:0];
         `PFS_OFF_IRQ   :
         begin
            irq_en  <= pwdata[15:0];
            irq_sel <= pwdata[31:16];
         end
         `PFS_OFF_CAP   : cap <= pwdata[7:0];
         default        : cap <= cap;
      endcase
   end
end

// ----------------------------------------
// output routing per pin
// ----------------------------------------
reg  [15:0] per_out;
reg  [15:0] per_oe;
reg  [15:0] trc_pin;
reg  [15:0] irq_pin;
integer     k;
integer     p;
integer     j;

wire [5:0]  wave_val = rsel[`PFS_RS_PPG] ?
   {{2{pulse_gen_output[2]}}, {2{pulse_gen_output[1]}}, {2{pulse_gen_output[0]}}} : waveform_output;
wire [4:0]  trc_val  = {trace_data_out, trace_clock_out};

always @*
begin
   per_out = 16'h0000;
   per_oe  = 16'h0000;
   trc_pin = 16'h0000;
   irq_pin = 16'h0000;
   p       = 0;
   if (a_sel != 2'h0)
   begin
      p = `PFS_BTA_BASE + a_sel - 1;
      per_out[p] = bt_a_out;
      per_oe[p]  = bt_a_oe;
   end
   if (b_sel != 2'h0)
   begin
      p = `PFS_BTB_BASE + b_sel - 1;
      per_out[p] = bt_b_out;
      per_oe[p]  = bt_b_oe;
   end
   if (rsel[`PFS_RS_WVE])
   begin
      for (k = 0; k < 6; k = k + 1)
      begin
         p = rsel[`PFS_RS_WVS] ? `PFS_WAV_POS1 + k : `PFS_WAV_POS0 + k;
         per_out[p] = wave_val[k];
         per_oe[p]  = 1'b1;
      end
   end
   if (rsel[`PFS_RS_TRC])
   begin
      for (k = 0; k < 5; k = k + 1)
      begin
         p = `PFS_TRC_BASE + k;
         per_out[p] = trc_val[k];
         per_oe[p]  = 1'b1;
         trc_pin[p] = 1'b1;
      end
   end
   for (k = 0; k < 16; k = k + 1)
   begin
      p = irq_sel[k] ? (k + `PFS_IRQ_ALT) % 16 : k;
      if (irq_en[k])
         irq_pin[p] = 1'b1;
   end
end

wire [15:0] keep    = {16{~supply_unstable}};
wire [15:0] stby_in = {16{hold}} & ~irq_pin;
assign pin_in = pad_in & keep & ~aen & ~stby_in;
wire [15:0] stby_oe = {16{hold}} & ~trc_pin & ~irq_pin;
// run or spl clear keeps state
wire [15:0] next_oe  = keep & ~aen & ~stby_oe & ((func & per_oe) | (~func & dir));
wire [15:0] next_out = (func & per_out) | (~func & dout);

// ----------------------------------------
// input routing to peripherals
// ----------------------------------------
reg         next_bta;
reg         next_btb;
reg         next_adt;
reg  [15:0] next_irq;
reg  [3:0]  next_cap;

always @*
begin
   next_bta = 1'b0;
   next_btb = 1'b0;
   next_irq = 16'h0000;
   next_cap = 4'h0;
   if (a_sel != 2'h0)
      next_bta = sel_in(pin_in, func, `PFS_BTA_BASE + a_sel - 1);
   if (b_sel != 2'h0)
      next_btb = sel_in(pin_in, func, `PFS_BTB_BASE + b_sel - 1);
   next_adt = rsel[`PFS_RS_ADE] & sel_in(pin_in, func, `PFS_ADT_BASE + ad_sel);
   for (j = 0; j < 16; j = j + 1)
      next_irq[j] = irq_en[j] & sel_in(pin_in, func, irq_sel[j] ? (j + `PFS_IRQ_ALT) % 16 : j);
   for (j = 0; j < 4; j = j + 1)
      next_cap[j] = cap_en[j] & sel_in(pin_in, func, cap_sel[j] ? `PFS_CAP_POS1 + j : `PFS_CAP_POS0 + j);
end

// ----------------------------------------
// registered pins and peripheral inputs
// ----------------------------------------
always @(posedge clk)
begin
   if (rst)
   begin
      pad_out              <= `PFS_RST_16;
      pad_oe               <= `PFS_RST_16;
      base_timer_io_a      <= 1'b0;
      base_timer_io_b      <= 1'b0;
      adc_ext_trigger      <= 1'b0;
      analog_channel_input <= `PFS_RST_16;
      waveform_disable_n   <= 1'b1;
      freerun_ext_clock    <= 1'b0;
      capture_input        <= 4'h0;
      ext_irq              <= `PFS_RST_16;
      nonmaskable_irq_n    <= 1'b1;
      addr_pad_out         <= 25'h0000000;
      addr_pad_oe          <= 1'b0;
      tms_pad_out          <= 1'b0;
      tms_pad_oe           <= 1'b0;
      tdo_pad_out          <= 1'b0;
      tdo_pad_oe           <= 1'b0;
      jtag_reset_n         <= 1'b0;
      dbg_clock            <= 1'b0;
      dbg_tms              <= 1'b0;
   end
   else
   begin
      pad_out              <= next_out;
      pad_oe               <= next_oe;
      base_timer_io_a      <= next_bta;
      base_timer_io_b      <= next_btb;
      adc_ext_trigger      <= next_adt;
      analog_channel_input <= aen & keep;
      // disable input, idle high when off
      waveform_disable_n   <= ~rsel[`PFS_RS_DIE] |
         sel_in(pin_in, func, `PFS_DIS_POS0 + rsel[`PFS_RS_DIS]);
      freerun_ext_clock    <= rsel[`PFS_RS_FRE] &
         sel_in(pin_in, func, `PFS_FRK_POS0 + rsel[`PFS_RS_FRS]);
      capture_input        <= next_cap;
      ext_irq              <= next_irq;
      // nmi follows its pin, held high while supply is unstable
      nonmaskable_irq_n    <= supply_unstable | nmi_pad_in;
      addr_pad_out         <= ext_bus_address;
      addr_pad_oe          <= rsel[`PFS_RS_EBE] & ~supply_unstable & ~hold;
      tms_pad_out          <= dbg_swdio_out;
      tms_pad_oe           <= rsel[`PFS_RS_SWJ] & dbg_swdio_oe & ~supply_unstable;
      tdo_pad_out          <= rsel[`PFS_RS_SWJ] ? swo_in : jtag_tdo;
      tdo_pad_oe           <= ~supply_unstable & (rsel[`PFS_RS_SWJ] | jtag_tdo_oe);
      dbg_clock            <= tck_pad_in;
      dbg_tms              <= tms_pad_in;
      jtag_reset_n         <= jtag_reset_pad_n;
   end
end

endmodule

// ---- pfs_pin_ctrl_asserts.sv ----
`timescale 1ns/10ps
module pfs_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        supply_unstable,
   input wire logic        external_reset_n,
   input wire logic        standby_mode,
   input wire logic [15:0] pad_oe,
   input wire logic        nmi_pad_in,
   input wire logic        nonmaskable_irq_n,
   input wire logic        tck_pad_in,
   input wire logic        tms_pad_in,
   input wire logic        dbg_clock,
   input wire logic        dbg_tms,
   input wire logic        jtag_reset_pad_n,
   input wire logic        jtag_reset_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // bus and pin state
   // ----------------------------------------
   property p_ready; psel && penable && !pready |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("ready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready stuck");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("stray error");
   // two cycles: in reset the config registers settle one edge late; supply_unstable masks pad_oe directly
   property p_unst; supply_unstable [*2] |=> pad_oe == 16'h0000; endproperty
   a_unst: assert property (p_unst) else $error("pad driven while unstable");
   property p_xrst; !external_reset_n [*2] |=> pad_oe == 16'h0000; endproperty
   a_xrst: assert property (p_xrst) else $error("pad driven in reset");
   property p_nmi; !supply_unstable && external_reset_n |=> nonmaskable_irq_n == $past(nmi_pad_in); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not kept");
   property p_dbg; !supply_unstable |=> dbg_clock == $past(tck_pad_in) && dbg_tms == $past(tms_pad_in); endproperty
   a_dbg: assert property (p_dbg) else $error("debug pins wrong");
   property p_trst; !supply_unstable |=> jtag_reset_n == $past(jtag_reset_pad_n); endproperty
   a_trst: assert property (p_trst) else $error("test reset wrong");
   c_err: cover property (pslverr);
   c_stby: cover property (standby_mode && pad_oe == 16'h0000);
   c_lock: cover property (!external_reset_n);
endmodule

// ---- pfs_pin_ctrl_tb.sv ----
`timescale 1ns/10ps
module pfs_pin_ctrl_tb;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        supply_unstable, external_reset_n, internal_reset, standby_mode;
   wire  [15:0] pad_in;
   logic [15:0] pad_out, pad_oe, drive, analog_channel_input, ext_irq;
   logic        bt_a_out, bt_a_oe, bt_b_out, bt_b_oe, base_timer_io_a, base_timer_io_b;
   logic        adc_ext_trigger, waveform_disable_n, freerun_ext_clock, trace_clock_out;
   logic [5:0]  waveform_output;
   logic [2:0]  pulse_gen_output;
   logic [3:0]  capture_input, trace_data_out;
   logic [24:0] ext_bus_address, addr_pad_out;
   logic        nmi_pad_in, nonmaskable_irq_n, addr_pad_oe, tck_pad_in, tms_pad_in, tms_pad_out;
   logic        tms_pad_oe, tdo_pad_out, tdo_pad_oe, jtag_reset_pad_n, jtag_reset_n, dbg_clock;
   logic        dbg_tms, dbg_swdio_out, dbg_swdio_oe, jtag_tdo, jtag_tdo_oe, swo_in;
   int          failures, checks;

   pfs_pin_ctrl dut (.*);
   pfs_board board (.pad_out(pad_out), .pad_oe(pad_oe), .drive(drive), .pad_in(pad_in));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         failures++;
      @(posedge clk);
   endtask
   // outputs are registered at most two edges after any change
   task wt;
      repeat (3) @(posedge clk);
   endtask
   task final_report;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_bus;
      apb(1, 8'h00, 32'hFFFF_A5A5);
      apb(0, 8'h00, 0);
      chk("func", 32'h0000_A5A5, q);
      apb(0, 8'h24, 0);
      chk("unmapped", 1, er);
      chk("unmapped_rd", 0, q);
   endtask
   task t_gpio;
      apb(1, 8'h00, 0);
      apb(1, 8'h04, 32'h00FF);
      apb(1, 8'h08, 32'h0055);
      drive <= 16'hA300;
      wt();
      chk("oe", 32'h00FF, pad_oe);
      chk("out", 32'h0055, pad_out & 16'h00FF);
      apb(0, 8'h0C, 0);
      chk("din", 32'hA355, q);
   endtask
   task t_standby;
      apb(1, 8'h14, 32'h0002_0000);
      standby_mode <= 1'b1;
      wt();
      chk("stby_oe", 0, pad_oe);
      apb(0, 8'h0C, 0);
      chk("stby_din", 0, q);
      standby_mode <= 1'b0;
      wt();
      chk("exit_oe", 32'h00FF, pad_oe);
      chk("exit_out", 32'h0055, pad_out & 16'h00FF);
      supply_unstable <= 1'b1;
      wt();
      chk("unst_oe", 0, pad_oe);
      supply_unstable <= 1'b0;
      wt();
   endtask
   task t_ppg;
      apb(1, 8'h00, 32'hFC00);
      apb(1, 8'h14, 32'h3000);
      waveform_output <= 6'h15;
      pulse_gen_output <= 3'b101;
      wt();
      chk("ppg", 6'h33, pad_out[15:10]);
      chk("ppg_oe", 6'h3F, pad_oe[15:10]);
      apb(1, 8'h14, 32'h1000);
      wt();
      chk("wave", 6'h15, pad_out[15:10]);
      apb(1, 8'h00, 32'h03F0);
      apb(1, 8'h14, 32'h1800);
      wt();
      chk("wave_pos1", 6'h15, pad_out[9:4]);
      chk("wave_pos0_oe", 6'h00, pad_oe[15:10]);
   endtask
   task t_misc;
      apb(1, 8'h10, 32'h8001);
      wt();
      chk("analog", 32'h8001, analog_channel_input);
      for (int i = 0; i < 2; i++)
      begin
         {tck_pad_in, tms_pad_in, nmi_pad_in, jtag_reset_pad_n} <= i ? 4'hA : 4'h5;
         wt();
         chk("dbg", i ? 4'hA : 4'h5, {dbg_clock, dbg_tms, nonmaskable_irq_n, jtag_reset_n});
      end
   endtask
   task t_lock;
      external_reset_n <= 1'b0;
      wt();
      apb(1, 8'h04, 32'hFFFF);
      apb(0, 8'h04, 0);
      chk("dir_lock", 0, q);
      chk("lock_oe", 0, pad_oe);
      external_reset_n <= 1'b1;
      wt();
      apb(0, 8'h00, 0);
      chk("func_clr", 0, q);
      apb(1, 8'h04, 32'hFFFF);
      internal_reset <= 1'b1;
      wt();
      chk("int_oe", 0, pad_oe);
      internal_reset <= 1'b0;
      wt();
      apb(0, 8'h04, 0);
      chk("int_dir", 0, q);
   endtask
   task t_timer;
      apb(1, 8'h00, 32'h03FF);
      apb(1, 8'h14, 32'h006E);
      {bt_a_out, bt_a_oe, bt_b_out, bt_b_oe} <= 4'hF;
      drive <= 16'h0100;
      wt();
      chk("tmr_oe", 16'h0022, pad_oe);
      chk("tmr_out", 16'h0022, pad_out);
      chk("tmr_a_in", 1, base_timer_io_a);
      chk("tmr_b_in", 1, base_timer_io_b);
      chk("adc_trig", 1, adc_ext_trigger);
      drive <= 16'h0040;
      wt();
      chk("adc_unsel", 0, adc_ext_trigger);
      {bt_a_out, bt_a_oe, bt_b_out, bt_b_oe} <= 4'h0;
   endtask
   task t_route;
      apb(1, 8'h00, 32'hFFFF);
      apb(1, 8'h14, 32'h0001_0580);
      apb(1, 8'h18, 32'h0008_0008);
      apb(1, 8'h1C, 32'h0000_0011);
      ext_bus_address <= 25'h1ABCDEF;
      drive <= 16'h8804;
      wt();
      chk("freerun", 1, freerun_ext_clock);
      chk("wave_dis", 0, waveform_disable_n);
      chk("irq", 16'h0008, ext_irq);
      chk("capture", 4'h1, capture_input);
      chk("addr", 25'h1ABCDEF, addr_pad_out);
      chk("addr_oe", 1, addr_pad_oe);
      apb(1, 8'h14, 32'h0003_0580);
      standby_mode <= 1'b1;
      wt();
      chk("stby_irq", 16'h0008, ext_irq);
      chk("stby_cap", 4'h0, capture_input);
      chk("stby_addr_oe", 0, addr_pad_oe);
      standby_mode <= 1'b0;
      drive <= 16'h0008;
      wt();
      chk("irq_unsel", 16'h0000, ext_irq);
   endtask
   task t_debug;
      apb(1, 8'h14, 32'h0000_C000);
      {dbg_swdio_out, dbg_swdio_oe, swo_in, trace_clock_out} <= 4'hF;
      trace_data_out <= 4'hA;
      wt();
      chk("swd_pins", 4'hF, {tms_pad_out, tms_pad_oe, tdo_pad_out, tdo_pad_oe});
      chk("trace_out", 5'h15, pad_out[4:0]);
      chk("trace_oe", 5'h1F, pad_oe[4:0]);
      apb(1, 8'h14, 32'h0002_C000);
      standby_mode <= 1'b1;
      wt();
      chk("stby_trace_oe", 5'h1F, pad_oe[4:0]);
      standby_mode <= 1'b0;
      apb(1, 8'h14, 32'h0000_0000);
      jtag_tdo <= 1'b0;
      jtag_tdo_oe <= 1'b1;
      wt();
      chk("jtag_pins", 3'b001, {tms_pad_oe, tdo_pad_out, tdo_pad_oe});
   endtask
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      #100000;
      failures++;
      final_report();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, supply_unstable, internal_reset, standby_mode} = '0;
      {drive, bt_a_out, bt_a_oe, bt_b_out, bt_b_oe, waveform_output, pulse_gen_output} = '0;
      {trace_clock_out, trace_data_out, ext_bus_address, tck_pad_in, tms_pad_in} = '0;
      {dbg_swdio_out, dbg_swdio_oe, jtag_tdo, jtag_tdo_oe, swo_in, failures, checks} = '0;
      {rst, external_reset_n, jtag_reset_pad_n, nmi_pad_in} = '1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_bus();
      t_gpio();
      t_standby();
      t_ppg();
      t_misc();
      t_lock();
      t_timer();
      t_route();
      t_debug();
      final_report();
   end
endmodule

bind pfs_pin_ctrl pfs_chk u_chk (
   .clk               (clk),
   .rst               (rst),
   .psel              (psel),
   .penable           (penable),
   .pready            (pready),
   .pslverr           (pslverr),
   .supply_unstable   (supply_unstable),
   .external_reset_n  (external_reset_n),
   .standby_mode      (standby_mode),
   .pad_oe            (pad_oe),
   .nmi_pad_in        (nmi_pad_in),
   .nonmaskable_irq_n (nonmaskable_irq_n),
   .tck_pad_in        (tck_pad_in),
   .tms_pad_in        (tms_pad_in),
   .dbg_clock         (dbg_clock),
   .dbg_tms           (dbg_tms),
   .jtag_reset_pad_n  (jtag_reset_pad_n),
   .jtag_reset_n      (jtag_reset_n)
);
